//--- hw/mgpwm_top.sv
// Multi-generator PWM block: APB registers, interrupts, output stage
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
// Contract
// - Period equals ticks between successive counter-zero events; in up/down mode an odd period gives one tick less.
// - Period read returns the latest programmed value.
// - A newer write replaces an older pending value.
// - Pulse-width read returns the programmed compare value.
// - Pulse width sets the length of the high portion in ticks.
// - Module interrupt enable: one bit per generator plus fault.
// - Raw and masked module status views, three generators plus fault.
// - Fault-kill outputs go inactive while a fault is active.
// - Outputs without fault-kill keep their waveform during faults.
// - Inversion set makes the output active low.
// - Inversion clear passes the waveform unchanged, active high.
// - Enabled outputs drive the waveform, disabled ones stay inactive.
// - Time-base sync zeroes all selected generator counters together.
// - Update sync applies queued changes at each selected generator's next zero.
// - Count-down mode left-aligned, up/down mode centre-aligned.
// - Sync mode waits for sync event; changes only apply at zero.
// - Writing one to a generator status bit clears that source.
module mgpwm_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fault_in,
  output logic [mgpwm_pkg::NOUT-1:0] pwm_out,
  output logic irq
);
  import mgpwm_pkg::*;

  // ==========================================================
  // Fault input synchroniser
  logic fault_m_q, fault_s_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_m_q <= 1'b0;
      fault_s_q <= 1'b0;
    end else begin
      fault_m_q <= fault_in;
      fault_s_q <= fault_m_q;
    end
  end

  // ==========================================================
  // APB decode
  wire setup = psel & ~penable;
  wire wr = psel & penable & pwrite;
  wire hit_ctrl = (paddr == OFS_CTRL);
  wire hit_tbsync = (paddr == OFS_TBSYNC);
  wire hit_updsync = (paddr == OFS_UPDSYNC);
  wire hit_outen = (paddr == OFS_OUTEN);
  wire hit_outinv = (paddr == OFS_OUTINV);
  wire hit_fkill = (paddr == OFS_FKILL);
  wire hit_inten = (paddr == OFS_INTEN);
  wire hit_ris = (paddr == OFS_RIS);
  wire hit_mis = (paddr == OFS_MIS);
  wire [1:0] gidx = gen_of(paddr);
  wire [4:0] goff = paddr[4:0];
  wire gen_win = (paddr >= OFS_GEN_BASE) & (paddr < OFS_GEN_END);
  wire goff_ok = (goff == GOFS_PERIOD) | (goff == GOFS_CMPA) | (goff == GOFS_CMPB) |
                 (goff == GOFS_INTEN) | (goff == GOFS_RIS) | (goff == GOFS_MIS) |
                 (goff == GOFS_COUNT);
  wire gen_hit = gen_win & goff_ok;
  wire mapped = hit_ctrl | hit_tbsync | hit_updsync | hit_outen | hit_outinv | hit_fkill |
                hit_inten | hit_ris | hit_mis | gen_hit;
  wire gwr = wr & gen_hit;

  // ==========================================================
  // Control registers
  logic [CTRL_W-1:0] ctrl_q;
  logic [NOUT-1:0] outen_q, outinv_q, fkill_q;
  logic [NMIRQ-1:0] inten_q;
  logic fault_st_q;
  logic [NGEV-1:0] gien_q [NGEN];
  logic [NGEV-1:0] gris_q [NGEN];
  logic [31:0] prdata_q;
  logic [NOUT-1:0] pwm_q;

  wire [NGEN-1:0] run = ctrl_q[CTRL_RUN_LSB +: NGEN];
  wire [NGEN-1:0] ud = ctrl_q[CTRL_UD_LSB +: NGEN];
  wire [NGEN-1:0] sm = ctrl_q[CTRL_SYNC_LSB +: NGEN];
  wire [NGEN-1:0] tb_sync = (wr & hit_tbsync) ? pwdata[NGEN-1:0] : '0;
  wire [NGEN-1:0] upd_sync = (wr & hit_updsync) ? pwdata[NGEN-1:0] : '0;

  // ==========================================================
  // Generators
  logic [CW-1:0] per_prog [NGEN];
  logic [CW-1:0] ca_prog [NGEN];
  logic [CW-1:0] cb_prog [NGEN];
  logic [CW-1:0] gcount [NGEN];
  logic [NGEV-1:0] gev [NGEN];
  logic [NOUT-1:0] raw;
  logic [NGEN-1:0] gen_any;

  for (genvar g = 0; g < NGEN; g++) begin : g_gen
    wire sel = gwr & (gidx == 2'(g));
    mgpwm_gen u_gen (
      .pclk(pclk),
      .presetn(presetn),
      .run(run[g]),
      .updown(ud[g]),
      .sync_mode(sm[g]),
      .period_wr(sel & (goff == GOFS_PERIOD)),
      .cmpa_wr(sel & (goff == GOFS_CMPA)),
      .cmpb_wr(sel & (goff == GOFS_CMPB)),
      .wdata(pwdata[CW-1:0]),
      .tb_sync(tb_sync[g]),
      .upd_sync(upd_sync[g]),
      .period_prog(per_prog[g]),
      .cmpa_prog(ca_prog[g]),
      .cmpb_prog(cb_prog[g]),
      .count(gcount[g]),
      .pwm_a(raw[2*g]),
      .pwm_b(raw[2*g+1]),
      .events(gev[g])
    );
    wire [NGEV-1:0] gclr = (sel & (goff == GOFS_RIS)) ? pwdata[NGEV-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        gien_q[g] <= '0;
        gris_q[g] <= '0;
      end else begin
        if (sel & (goff == GOFS_INTEN)) gien_q[g] <= pwdata[NGEV-1:0];
        gris_q[g] <= gev[g] | (gris_q[g] & ~gclr);
      end
    end
    assign gen_any[g] = |(gris_q[g] & gien_q[g]);
  end

  // ==========================================================
  // Module interrupts
  wire fault_clr = wr & hit_ris & pwdata[MIRQ_FAULT_BIT];
  wire [NMIRQ-1:0] ris = {fault_st_q, gen_any};
  wire [NMIRQ-1:0] mis = ris & inten_q;

  // ==========================================================
  // Output stage
  wire [NOUT-1:0] killed = fkill_q & {NOUT{fault_s_q}};
  wire [NOUT-1:0] live = outen_q & ~killed;
  wire [NOUT-1:0] wave_d = ((raw ^ outinv_q) & live) | (outinv_q & ~live);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      outen_q <= OUT_RST;
      outinv_q <= OUT_RST;
      fkill_q <= OUT_RST;
      inten_q <= '0;
      fault_st_q <= 1'b0;
      pwm_q <= OUT_RST;
    end else begin
      if (wr & hit_ctrl) ctrl_q <= pwdata[CTRL_W-1:0];
      if (wr & hit_outen) outen_q <= pwdata[NOUT-1:0];
      if (wr & hit_outinv) outinv_q <= pwdata[NOUT-1:0];
      if (wr & hit_fkill) fkill_q <= pwdata[NOUT-1:0];
      if (wr & hit_inten) inten_q <= pwdata[NMIRQ-1:0];
      fault_st_q <= fault_s_q | (fault_st_q & ~fault_clr);
      pwm_q <= wave_d;
    end
  end

  // ==========================================================
  // Read path
  wire [1:0] gi = gen_hit ? gidx : 2'h0;
  wire [31:0] grd = (goff == GOFS_PERIOD) ? {16'h0000, per_prog[gi]} :
                    (goff == GOFS_CMPA) ? {16'h0000, ca_prog[gi]} :
                    (goff == GOFS_CMPB) ? {16'h0000, cb_prog[gi]} :
                    (goff == GOFS_INTEN) ? {26'h0, gien_q[gi]} :
                    (goff == GOFS_RIS) ? {26'h0, gris_q[gi]} :
                    (goff == GOFS_MIS) ? {26'h0, gris_q[gi] & gien_q[gi]} :
                    (goff == GOFS_COUNT) ? {16'h0000, gcount[gi]} : 32'h0;
  wire [31:0] rd_val = hit_ctrl ? {23'h0, ctrl_q} :
                       hit_outen ? {26'h0, outen_q} :
                       hit_outinv ? {26'h0, outinv_q} :
                       hit_fkill ? {26'h0, fkill_q} :
                       hit_inten ? {28'h0, inten_q} :
                       hit_ris ? {28'h0, ris} :
                       hit_mis ? {28'h0, mis} :
                       gen_hit ? grd : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (setup) begin
      prdata_q <= rd_val;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign pwm_out = pwm_q;
  assign irq = |mis;

  // ==========================================================
  // Assertions
  default clocking cb_top @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_kill;
    ((pwm_out ^ $past(outinv_q)) & $past(killed)) == '0;
  endproperty
  a_kill: assert property (p_kill) else $error("killed output not inactive");

  property p_disabled;
    ((pwm_out ^ $past(outinv_q)) & ~$past(outen_q)) == '0;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled output not inactive");

  property p_pass;
    ((pwm_out ^ $past(raw ^ outinv_q)) & $past(live)) == '0;
  endproperty
  a_pass: assert property (p_pass) else $error("live output wrong waveform");

  property p_fault_st;
    fault_s_q |=> fault_st_q;
  endproperty
  a_fault_st: assert property (p_fault_st) else $error("fault status not set");

  property p_irq;
    irq == |({fault_st_q, gen_any} & inten_q);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not masked status");

  property p_gclr;
    (gwr && gidx == 2'h0 && goff == GOFS_RIS && pwdata[GEV_ZERO] && !gev[0][GEV_ZERO])
      |=> !gris_q[0][GEV_ZERO];
  endproperty
  a_gclr: assert property (p_gclr) else $error("status bit not cleared");

  sequence s_tb_pair;
    wr && hit_tbsync && pwdata[0] && pwdata[1];
  endsequence

  sequence s_kill0;
    fault_s_q && fkill_q[0];
  endsequence

  property p_tb_pair;
    s_tb_pair |=> (gcount[0] == gcount[1]);
  endproperty
  a_tb_pair: assert property (p_tb_pair) else $error("synced counters differ");

  property p_kill0;
    s_kill0 |=> (pwm_out[0] == $past(outinv_q[0]));
  endproperty
  a_kill0: assert property (p_kill0) else $error("output 0 not killed");

  property p_nokill;
    (fault_s_q && !fkill_q[1] && outen_q[1])
      |=> (pwm_out[1] == $past(raw[1] ^ outinv_q[1]));
  endproperty
  a_nokill: assert property (p_nokill) else $error("output 1 lost waveform");

  property p_rd_period;
    (setup && gen_hit && gi == 2'h0 && goff == GOFS_PERIOD)
      |=> (prdata[CW-1:0] == $past(per_prog[0]));
  endproperty
  a_rd_period: assert property (p_rd_period) else $error("period read wrong");

  property p_rd_width;
    (setup && gen_hit && gi == 2'h0 && goff == GOFS_CMPA)
      |=> (prdata[CW-1:0] == $past(ca_prog[0]));
  endproperty
  a_rd_width: assert property (p_rd_width) else $error("width read wrong");

  property p_rd_hold;
    (psel && penable) |=> $stable(prdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data not held");

  property p_inten_wr;
    (wr && hit_inten) |=> (inten_q == $past(pwdata[NMIRQ-1:0]));
  endproperty
  a_inten_wr: assert property (p_inten_wr) else $error("enable write lost");

  property p_fault_clr;
    (fault_clr && !fault_s_q) |=> !fault_st_q;
  endproperty
  a_fault_clr: assert property (p_fault_clr) else $error("fault status not cleared");

  property p_gen_irq;
    (gen_any[0] && inten_q[0]) |-> irq;
  endproperty
  a_gen_irq: assert property (p_gen_irq) else $error("generator irq missing");

  property p_mis_fault;
    (fault_st_q && !inten_q[MIRQ_FAULT_BIT]) |-> !mis[MIRQ_FAULT_BIT];
  endproperty
  a_mis_fault: assert property (p_mis_fault) else $error("masked fault shown");

endmodule : mgpwm_top

//--- hw/mgpwm_pkg.sv
// Constants, types and helpers shared by the multi-generator PWM block
package mgpwm_pkg;

  // ==========================================================
  // Sizes
  localparam int unsigned NGEN = 3;
  localparam int unsigned NOUT = 6;
  localparam int unsigned CW = 16;
  localparam int unsigned NGEV = 6;
  localparam int unsigned NMIRQ = 4;

  // ==========================================================
  // Module register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_TBSYNC = 12'h004;
  localparam logic [11:0] OFS_UPDSYNC = 12'h008;
  localparam logic [11:0] OFS_OUTEN = 12'h00c;
  localparam logic [11:0] OFS_OUTINV = 12'h010;
  localparam logic [11:0] OFS_FKILL = 12'h014;
  localparam logic [11:0] OFS_INTEN = 12'h018;
  localparam logic [11:0] OFS_RIS = 12'h01c;
  localparam logic [11:0] OFS_MIS = 12'h020;
  localparam logic [11:0] OFS_GEN_BASE = 12'h040;
  localparam logic [11:0] OFS_GEN_END = 12'h0a0;

  // Generator register offsets inside a 32-byte window
  localparam logic [4:0] GOFS_PERIOD = 5'h00;
  localparam logic [4:0] GOFS_CMPA = 5'h04;
  localparam logic [4:0] GOFS_CMPB = 5'h08;
  localparam logic [4:0] GOFS_INTEN = 5'h0c;
  localparam logic [4:0] GOFS_RIS = 5'h10;
  localparam logic [4:0] GOFS_MIS = 5'h14;
  localparam logic [4:0] GOFS_COUNT = 5'h18;

  // ==========================================================
  // Field positions
  localparam int unsigned CTRL_RUN_LSB = 0;
  localparam int unsigned CTRL_UD_LSB = 3;
  localparam int unsigned CTRL_SYNC_LSB = 6;
  localparam int unsigned CTRL_W = 9;
  localparam int unsigned MIRQ_FAULT_BIT = 3;
  localparam int unsigned GEV_ZERO = 0;
  localparam int unsigned GEV_LOAD = 1;
  localparam int unsigned GEV_AU = 2;
  localparam int unsigned GEV_AD = 3;
  localparam int unsigned GEV_BU = 4;
  localparam int unsigned GEV_BD = 5;

  // ==========================================================
  // Reset values
  localparam logic [CW-1:0] PERIOD_RST = 16'h0000;
  localparam logic [CW-1:0] CMP_RST = 16'h0000;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  localparam logic [NOUT-1:0] OUT_RST = 6'h00;

  typedef enum logic {
    MGPWM_DIR_DOWN = 1'b0,
    MGPWM_DIR_UP = 1'b1
  } mgpwm_dir_e;

  // Turning point of the counter for a given period and mode
  function automatic logic [CW-1:0] load_of(input logic [CW-1:0] per, input logic ud);
    if (per == '0) begin
      return '0;
    end
    return ud ? (per >> 1) : CW'(per - 16'h0001);
  endfunction : load_of

  // High portion of an output lasts w ticks
  // Up/down: rising side takes the odd tick of an odd width
  function automatic logic wave_of(input logic [CW-1:0] cnt, input logic [CW-1:0] load,
                                   input logic [CW-1:0] w, input logic ud, input logic up);
    logic [CW:0] sum;
    logic [CW:0] half_up;
    sum = {1'b0, cnt} + {1'b0, w};
    half_up = ({1'b0, w} + 17'h00001) >> 1;
    if (ud) begin
      return up ? ({1'b0, cnt} < half_up) : (cnt <= (w >> 1));
    end
    return sum > {1'b0, load};
  endfunction : wave_of

  // Generator index of an address in the generator windows
  function automatic logic [1:0] gen_of(input logic [11:0] addr);
    logic [11:0] rel;
    rel = addr - OFS_GEN_BASE;
    return rel[6:5];
  endfunction : gen_of

endpackage : mgpwm_pkg

//--- hw/mgpwm_gen.sv
// One PWM generator: counter, queued parameters, two compare outputs
`timescale 1ns/1ps
module mgpwm_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic updown,
  input wire logic sync_mode,
  input wire logic period_wr,
  input wire logic cmpa_wr,
  input wire logic cmpb_wr,
  input wire logic [mgpwm_pkg::CW-1:0] wdata,
  input wire logic tb_sync,
  input wire logic upd_sync,
  output logic [mgpwm_pkg::CW-1:0] period_prog,
  output logic [mgpwm_pkg::CW-1:0] cmpa_prog,
  output logic [mgpwm_pkg::CW-1:0] cmpb_prog,
  output logic [mgpwm_pkg::CW-1:0] count,
  output logic pwm_a,
  output logic pwm_b,
  output logic [mgpwm_pkg::NGEV-1:0] events
);
  import mgpwm_pkg::*;

  logic [CW-1:0] cnt_q, cnt_d;
  mgpwm_dir_e dir_q, dir_d;
  logic [CW-1:0] per_act_q, ca_act_q, cb_act_q;
  logic [CW-1:0] per_prog_q, ca_prog_q, cb_prog_q;
  logic pend_q, armed_q, a_q, b_q;

  // ==========================================================
  // Counter
  wire [CW-1:0] load_val = load_of(per_act_q, updown);
  wire at_zero = (cnt_q == '0);
  wire up_eff = (dir_q == MGPWM_DIR_UP) | at_zero;
  wire [CW-1:0] cnt_inc = CW'(cnt_q + 16'h0001);
  wire [CW-1:0] cnt_dec = CW'(cnt_q - 16'h0001);
  wire [CW-1:0] ud_next = (load_val == '0) ? '0 : (up_eff ? cnt_inc : cnt_dec);
  wire [CW-1:0] dn_next = at_zero ? load_val : cnt_dec;

  always_comb begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    if (tb_sync) begin
      cnt_d = '0;
      dir_d = MGPWM_DIR_UP;
    end else if (run && updown) begin
      cnt_d = ud_next;
      if (up_eff) begin
        dir_d = (cnt_inc >= load_val) ? MGPWM_DIR_DOWN : MGPWM_DIR_UP;
      end else begin
        dir_d = (cnt_dec == '0) ? MGPWM_DIR_UP : MGPWM_DIR_DOWN;
      end
    end else if (run) begin
      cnt_d = dn_next;
      dir_d = MGPWM_DIR_DOWN;
    end
  end

  // ==========================================================
  // Queued parameters
  wire any_wr = period_wr | cmpa_wr | cmpb_wr;
  wire apply = run & at_zero & pend_q & (~sync_mode | armed_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      dir_q <= MGPWM_DIR_UP;
      per_prog_q <= PERIOD_RST;
      ca_prog_q <= CMP_RST;
      cb_prog_q <= CMP_RST;
      per_act_q <= PERIOD_RST;
      ca_act_q <= CMP_RST;
      cb_act_q <= CMP_RST;
      pend_q <= 1'b0;
      armed_q <= 1'b0;
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      // Newest write replaces any older pending value
      if (period_wr) per_prog_q <= wdata;
      if (cmpa_wr) ca_prog_q <= wdata;
      if (cmpb_wr) cb_prog_q <= wdata;
      if (apply) begin
        per_act_q <= per_prog_q;
        ca_act_q <= ca_prog_q;
        cb_act_q <= cb_prog_q;
      end
      // A write in the apply cycle stays pending for the next zero
      pend_q <= any_wr | (pend_q & ~apply);
      armed_q <= upd_sync | (armed_q & ~apply);
      a_q <= run & wave_of(cnt_q, load_val, ca_act_q, updown, up_eff);
      b_q <= run & wave_of(cnt_q, load_val, cb_act_q, updown, up_eff);
    end
  end

  // ==========================================================
  // Outputs
  assign period_prog = per_prog_q;
  assign cmpa_prog = ca_prog_q;
  assign cmpb_prog = cb_prog_q;
  assign count = cnt_q;
  assign pwm_a = a_q;
  assign pwm_b = b_q;
  assign events[GEV_ZERO] = run & at_zero;
  assign events[GEV_LOAD] = run & (cnt_q == load_val);
  assign events[GEV_AU] = run & (cnt_q == ca_act_q) & up_eff;
  assign events[GEV_AD] = run & (cnt_q == ca_act_q) & ~up_eff;
  assign events[GEV_BU] = run & (cnt_q == cb_act_q) & up_eff;
  assign events[GEV_BD] = run & (cnt_q == cb_act_q) & ~up_eff;

  // ==========================================================
  // Assertions
  default clocking cb_gen @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_armed_zero;
    run && at_zero && pend_q && armed_q && sync_mode;
  endsequence

  property p_prog_wr;
    period_wr |=> (per_prog_q == $past(wdata));
  endproperty
  a_prog_wr: assert property (p_prog_wr) else $error("period write not kept");

  property p_apply_zero;
    (per_act_q != $past(per_act_q)) |-> $past(at_zero && run);
  endproperty
  a_apply_zero: assert property (p_apply_zero) else $error("period applied off zero");

  property p_sync_hold;
    (sync_mode && !armed_q) |=> $stable(per_act_q);
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync update not held");

  property p_sync_apply;
    s_armed_zero |=> (per_act_q == $past(per_prog_q));
  endproperty
  a_sync_apply: assert property (p_sync_apply) else $error("armed update not applied");

  property p_tb_sync;
    tb_sync |=> (cnt_q == '0);
  endproperty
  a_tb_sync: assert property (p_tb_sync) else $error("counter not reset by sync");

  property p_reload;
    (run && !updown && at_zero && !tb_sync) |=> (cnt_q == $past(load_val));
  endproperty
  a_reload: assert property (p_reload) else $error("down counter did not reload");

  property p_centre;
    (run && updown && at_zero && !tb_sync && load_val != '0) |=> (cnt_q == 16'h0001);
  endproperty
  a_centre: assert property (p_centre) else $error("up/down counter not rising");

endmodule : mgpwm_gen

//--- tb/mgpwm_load.sv
// Load model: measures high time and period of every PWM output
`timescale 1ns/1ps
module mgpwm_load (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [mgpwm_pkg::NOUT-1:0] pwm_in,
  output logic [15:0] hi_len [mgpwm_pkg::NOUT],
  output logic [15:0] per_len [mgpwm_pkg::NOUT],
  output logic [15:0] edges [mgpwm_pkg::NOUT]
);
  import mgpwm_pkg::*;
  logic [NOUT-1:0] prev_q;
  logic [15:0] hcnt_q [NOUT];
  logic [15:0] pcnt_q [NOUT];

  // ==========================================================
  // Run-length counters, one set per output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= '0;
      for (int i = 0; i < NOUT; i++) begin
        hcnt_q[i] <= '0;
        pcnt_q[i] <= '0;
        hi_len[i] <= '0;
        per_len[i] <= '0;
        edges[i] <= '0;
      end
    end else begin
      prev_q <= pwm_in;
      for (int i = 0; i < NOUT; i++) begin
        if (pwm_in[i] && !prev_q[i]) begin
          per_len[i] <= pcnt_q[i];
          pcnt_q[i] <= 16'h0001;
          edges[i] <= edges[i] + 16'h0001;
        end else begin
          pcnt_q[i] <= pcnt_q[i] + 16'h0001;
        end
        if (pwm_in[i]) begin
          hcnt_q[i] <= prev_q[i] ? hcnt_q[i] + 16'h0001 : 16'h0001;
        end else if (prev_q[i]) begin
          hi_len[i] <= hcnt_q[i];
        end
      end
    end
  end
endmodule : mgpwm_load

//--- tb/mgpwm_top_test.sv
// Self-checking bench for the multi-generator PWM block
`timescale 1ns/1ps
module mgpwm_top_test;
  import mgpwm_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fault_in = 1'b0;
  logic [NOUT-1:0] pwm_out;
  logic irq;
  logic [15:0] hi_len [NOUT];
  logic [15:0] per_len [NOUT];
  logic [15:0] edges [NOUT];
  int fail_count = 0;
  int checked = 0;
  int bad;
  logic [31:0] seed = 32'h308345f1;
  logic [31:0] r;
  logic e;
  logic [15:0] e0;
  logic [15:0] e1;

  mgpwm_top u_mgpwm_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault_in(fault_in), .pwm_out(pwm_out), .irq(irq));
  mgpwm_load u_mgpwm_load (.pclk(pclk), .presetn(presetn), .pwm_in(pwm_out),
    .hi_len(hi_len), .per_len(per_len), .edges(edges));

  initial begin
    forever #5 pclk = ~pclk;
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [11:0] ga(input int g, input logic [4:0] o);
    return OFS_GEN_BASE + 12'(g * 32) + {7'h00, o};
  endfunction : ga
  function automatic logic [31:0] z(input logic [15:0] x);
    return {16'h0000, x};
  endfunction : z
  function automatic logic [31:0] b(input logic x);
    return {31'h0, x};
  endfunction : b
  function automatic logic [15:0] hi_exp(input logic [15:0] w, input logic [15:0] p,
                                         input logic inv);
    return inv ? p - w : w;
  endfunction : hi_exp

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(a, 1'b0, 32'h0);
    chk(what, exp, r);
  endtask : rd
  task automatic ticks(input int n);
    repeat (n) @(posedge pclk);
  endtask : ticks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    ticks(5000);
    fail_count++;
    report_and_stop();
  end

  // ==========================================================
  // Main sequence
  initial begin
    ticks(12);
    presetn <= 1'b1;
    rd(OFS_CTRL, 32'h0, "ctrl");
    rd(OFS_RIS, 32'h0, "ris");
    chk("irq", 32'h0, b(irq));
    rd(12'h05c, 32'h0, "unmapped");
    chk("slverr", 32'h1, b(e));
    for (int g = 0; g < NGEN; g++) begin
      seed = xs(seed);
      wr(ga(g, GOFS_PERIOD), seed);
      wr(ga(g, GOFS_PERIOD), {seed[15:0], seed[31:16]});
      rd(ga(g, GOFS_PERIOD), z(seed[31:16]), "period");
      wr(ga(g, GOFS_CMPB), z(seed[31:16]));
      wr(ga(g, GOFS_CMPB), seed);
      rd(ga(g, GOFS_CMPB), z(seed[15:0]), "width");
    end
    wr(ga(0, GOFS_PERIOD), 32'd10);
    wr(ga(0, GOFS_CMPA), 32'd3);
    wr(ga(0, GOFS_CMPB), 32'd7);
    wr(OFS_OUTEN, 32'h03);
    wr(OFS_OUTINV, 32'h02);
    wr(OFS_CTRL, 32'h001);
    ticks(40);
    chk("period0", 32'd10, z(per_len[0]));
    chk("high0", z(hi_exp(3, 10, 0)), z(hi_len[0]));
    chk("period1", 32'd10, z(per_len[1]));
    chk("high1", z(hi_exp(7, 10, 1)), z(hi_len[1]));
    wr(OFS_OUTEN, 32'h02);
    ticks(4);
    e0 = edges[0];
    ticks(30);
    chk("off_edges", z(e0), z(edges[0]));
    chk("off_level", 32'h0, b(pwm_out[0]));
    wr(OFS_OUTEN, 32'h03);
    wr(OFS_FKILL, 32'h01);
    fault_in <= 1'b1;
    ticks(5);
    e0 = edges[0];
    e1 = edges[1];
    ticks(30);
    chk("killed", z(e0), z(edges[0]));
    chk("kill_level", 32'h0, b(pwm_out[0]));
    chk("unkilled", 32'h1, b(edges[1] > e1 + 16'd1));
    rd(OFS_RIS, 32'h8, "ris");
    rd(OFS_MIS, 32'h0, "mis");
    chk("irq", 32'h0, b(irq));
    wr(OFS_INTEN, 32'h8);
    rd(OFS_MIS, 32'h8, "mis");
    chk("irq", 32'h1, b(irq));
    fault_in <= 1'b0;
    ticks(5);
    wr(OFS_RIS, 32'h8);
    rd(OFS_RIS, 32'h0, "ris");
    chk("irq", 32'h0, b(irq));
    wr(ga(0, GOFS_INTEN), 32'h01);
    wr(OFS_INTEN, 32'h1);
    ticks(12);
    rd(ga(0, GOFS_MIS), 32'h01, "gen_mis");
    rd(OFS_RIS, 32'h1, "ris_gen");
    chk("irq", 32'h1, b(irq));
    wr(OFS_CTRL, 32'h000);
    wr(ga(0, GOFS_RIS), 32'h3f);
    rd(ga(0, GOFS_RIS), 32'h0, "gen_ris");
    chk("irq", 32'h0, b(irq));
    wr(OFS_INTEN, 32'h0);
    wr(ga(1, GOFS_PERIOD), 32'd10);
    wr(ga(1, GOFS_CMPA), 32'd3);
    wr(OFS_CTRL, 32'h001);
    seed = xs(seed);
    ticks(1 + int'(seed[1:0]));
    wr(OFS_CTRL, 32'h003);
    wr(OFS_OUTEN, 32'h05);
    wr(OFS_OUTINV, 32'h00);
    wr(OFS_TBSYNC, 32'h3);
    ticks(3);
    bad = 0;
    repeat (30) begin
      @(posedge pclk);
      if (pwm_out[0] !== pwm_out[2]) bad++;
    end
    chk("aligned", 32'h0, 32'(bad));
    wr(OFS_CTRL, 32'h043);
    wr(ga(0, GOFS_CMPA), 32'd6);
    rd(ga(0, GOFS_CMPA), 32'd6, "width_prog");
    ticks(30);
    chk("held_high", z(hi_exp(3, 10, 0)), z(hi_len[0]));
    wr(OFS_UPDSYNC, 32'h1);
    ticks(30);
    chk("synced_high", z(hi_exp(6, 10, 0)), z(hi_len[0]));
    wr(ga(2, GOFS_PERIOD), 32'd20);
    wr(ga(2, GOFS_CMPA), 32'd8);
    wr(OFS_CTRL, 32'h027);
    wr(OFS_OUTEN, 32'h10);
    ticks(60);
    chk("period_ud", 32'd20, z(per_len[4]));
    chk("high_ud", 32'd8, z(hi_len[4]));
    report_and_stop();
  end
endmodule : mgpwm_top_test
